// *** bench/ddr_memory_command_decode_tb_top.sv ***
// Testbench: controller model, reference model, output comparisons
// Assumes decoder answers two edges after a command is sampled
`timescale 1ns/100ps

module ddr_memory_command_decode_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        allow_bad = 1'b0;
  logic        cs_n, ras_n, cas_n, we_n, pd_n;
  logic [2:0]  bank, cb, x_cb;
  logic [10:0] addr, ca, x_ca;
  logic [3:0]  mask, lb, x_lb;
  logic [12:0] mv, x_mv;
  logic [7:0]  act, m_open;
  logic        rd, st, ac, ml, rf, rm, pdo, hiz, x_ac, m_pd;
  logic [31:0] seed = 32'h615362a1;
  int          m_pwr, failures, comparisons;

  ddrc_ctrl_model u_ddrc_ctrl_model (
    .i_clk(clk), .i_allow_bad(allow_bad), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_power_down_n(pd_n), .o_bank(bank),
    .o_addr(addr), .o_byte_mask(mask));

  ddrc_decode u_ddrc_decode (
    .i_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_ras_n(ras_n),
    .i_cas_n(cas_n), .i_we_n(we_n), .i_power_down_n(pd_n), .i_bank(bank),
    .i_addr(addr), .i_byte_mask(mask), .o_bank_active(act),
    .o_read_start(rd), .o_store_start(st), .o_auto_close(ac), .o_col_bank(cb),
    .o_col_addr(ca), .o_mode_load(ml), .o_mode_value(mv), .o_refresh(rf),
    .o_restore_mode(rm), .o_power_down(pdo), .o_dq_hiz(hiz), .o_lane_block(lb));

  initial begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // One command through controller, reference model and checks
  // --------------------------------------------------------------
  task automatic step(input logic [4:0] c, input logic [2:0] b, input logic [10:0] a);
    logic [4:0] p;
    logic       e_rd, e_st, e_ml, e_rf;
    {e_rd, e_st, e_ml, e_rf} = 4'h0;
    seed = lfsr(seed);
    u_ddrc_ctrl_model.issue(c, b, a, seed[3:0]);
    p = {pd_n, cs_n, ras_n, cas_n, we_n};
    if (m_pwr == 0 && m_pd && p[4] && !p[3]) begin
      case (p[2:0])
        3'h4, 3'h5: if (m_open[b]) begin
          e_rd = p[0];
          e_st = !p[0];
          x_ac = a[10];
          x_cb = b;
          x_ca = a;
          x_lb = seed[3:0];
          if (a[10])
            m_open[b] = 1'b0;
        end
        3'h3: m_open[b] = 1'b1;
        3'h2: m_open = a[10] ? 8'h00 : m_open & ~(8'h01 << b);
        3'h1: e_rf = (m_open == 8'h00);
        3'h0: if (!a[10] && m_open == 8'h00) begin
          e_ml = 1'b1;
          x_mv = {b, a[9:0]};
        end
        default: ;
      endcase
    end else if (m_pwr == 0 && m_pd && !p[4])
      m_pwr = (p[3:0] == 4'h1) ? 1 : ((p[3] || p[2:0] == 3'h7) ? 2 : 0);
    else if (m_pwr != 0 && p[4] && (p[3] || p[2:0] == 3'h7))
      m_pwr = 0;
    m_pd = p[4];
    u_ddrc_ctrl_model.rest();
    repeat (2) @(negedge clk);
    check({rd, st}, {e_rd, e_st});
    check({ml, rf}, {e_ml, e_rf});
    check({ac, cb, ca}, {x_ac, x_cb, x_ca});
    check(mv, x_mv);
    if (e_st)
      check(lb, x_lb);
    @(negedge clk);
    check({rd, st, ml, rf}, 4'h0);
    repeat (4) @(negedge clk);
    check(act, m_open);
    check({rm, pdo, hiz}, {m_pwr == 1, m_pwr == 2, m_pwr != 0});
  endtask

  // Watchdog: about forty commands of nine cycles, with wide margin
  initial begin
    #50000;
    failures++;
    end_sim();
  end

  initial begin
    {x_cb, x_ca, x_lb, x_mv, x_ac, m_open} = '0;
    m_pd = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    step(5'h12, 3'h0, 11'h400);
    seed = lfsr(seed);
    step(5'h10, seed[6:4], {1'b0, seed[17:8]});
    step(5'h10, 3'h5, 11'h4aa);
    step(5'h1f, 3'h1, 11'h123);
    step(5'h17, 3'h1, 11'h123);
    step(5'h16, 3'h1, 11'h123);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      step(5'h13, i[2:0], seed[10:0]);
    end
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      step({3'h5, 1'b0, seed[0]}, i[2:0], {1'b0, seed[17:8]});
    end
    step(5'h12, 3'h2, 11'h000);
    step(5'h15, 3'h3, 11'h400);
    step(5'h14, 3'h4, 11'h47f);
    allow_bad = 1'b1;
    step(5'h15, 3'h2, 11'h011);
    step(5'h11, 3'h0, 11'h000);
    step(5'h10, 3'h0, 11'h000);
    allow_bad = 1'b0;
    seed = lfsr(seed);
    step(5'h12, seed[2:0], 11'h400);
    step(5'h11, 3'h0, 11'h000);
    step(5'h01, 3'h0, 11'h000);
    allow_bad = 1'b1;
    step(5'h03, 3'h1, 11'h000);
    allow_bad = 1'b0;
    step(5'h1f, 3'h0, 11'h000);
    step(5'h07, 3'h0, 11'h000);
    step(5'h0f, 3'h0, 11'h000);
    step(5'h17, 3'h0, 11'h000);
    step(5'h13, 3'h5, 11'h2c1);
    end_sim();
  end
endmodule // ddr_memory_command_decode_tb_top

// *** bench/ddrc_ctrl_model.sv ***
// Controller model: drives command, bank, address, power-down and masks
// Assumes the decoder samples all of its pins on the rising clock edge
`timescale 1ns/100ps

module ddrc_ctrl_model (
  input  wire logic   i_clk,
  input  wire logic   i_allow_bad,
  output logic        o_cs_n,
  output logic        o_ras_n,
  output logic        o_cas_n,
  output logic        o_we_n,
  output logic        o_power_down_n,
  output logic [2:0]  o_bank,
  output logic [10:0] o_addr,
  output logic [3:0]  o_byte_mask
);
  logic [7:0] open_q;

  initial begin
    {o_power_down_n, o_cs_n, o_ras_n, o_cas_n, o_we_n} = 5'h1f;
    o_bank = 3'h0;
    o_addr = 11'h000;
    o_byte_mask = 4'h0;
    open_q = 8'h00;
  end

  // --------------------------------------------------------------
  // One command cycle; c is power-down, select and three strobes
  // --------------------------------------------------------------
  task automatic issue(input logic [4:0] c, input logic [2:0] b,
                       input logic [10:0] a, input logic [3:0] m);
    logic ok;
    ok = 1'b1;
    if (c[3:0] inside {4'h4, 4'h5} && !open_q[b])
      ok = 1'b0;
    if (c[3:0] == 4'h3 && open_q[b])
      ok = 1'b0;
    if (c[3:0] inside {4'h0, 4'h1} && open_q != 8'h00)
      ok = 1'b0;
    @(negedge i_clk);
    {o_power_down_n, o_cs_n, o_ras_n, o_cas_n, o_we_n} =
      (ok || i_allow_bad) ? c : {c[4], 4'h7};
    o_bank = b;
    o_addr = a;
    o_byte_mask = m;
    if (ok && c[4]) begin
      if (c[3:0] == 4'h3)
        open_q[b] = 1'b1;
      if (c[3:0] == 4'h2)
        open_q = a[10] ? 8'h00 : open_q & ~(8'h01 << b);
      if (c[3:0] inside {4'h4, 4'h5} && a[10])
        open_q[b] = 1'b0;
    end
  endtask

  // Back to no-operation, address lines turned over
  task automatic rest();
    @(negedge i_clk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h7;
    o_bank = ~o_bank;
    o_addr = ~o_addr;
  endtask
endmodule // ddrc_ctrl_model

// *** hdl/ddrc_bank.sv ***
// One bank state tracker: idle, opening (row-to-column delay), active
// Assumes decoded, one-cycle command strobes from the command decoder
`timescale 1ns/100ps
`include "ddrc_map.svh"

module ddrc_bank
  import ddrc_pkg::*;
#(
  parameter int RCD_CYC = `DDRC_RCD_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_open,
  input  wire logic i_shut,
  output logic      o_active,
  output logic      o_idle
);

  ddrc_bank_t  state_q;
  logic [7:0]  cnt_q;

  // --------------------------------------------------------------------------
  // Bank state
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= DDRC_BANK_IDLE;
      cnt_q   <= 8'h00;
    end else begin
      case (state_q)
        DDRC_BANK_IDLE: begin
          if (i_open) begin
            state_q <= DDRC_BANK_OPENING;
            cnt_q   <= 8'(RCD_CYC - 1);
          end
        end
        DDRC_BANK_OPENING: begin
          if (cnt_q == 8'h00) begin
            state_q <= DDRC_BANK_ACTIVE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        DDRC_BANK_ACTIVE: begin
          if (i_shut) begin
            state_q <= DDRC_BANK_IDLE;
          end
        end
        default: state_q <= DDRC_BANK_IDLE;
      endcase
    end
  end

  assign o_active = (state_q == DDRC_BANK_ACTIVE);
  assign o_idle   = (state_q == DDRC_BANK_IDLE);

  AST_RCD_WAIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == DDRC_BANK_IDLE && i_open) |=> !o_active ##1 !o_active)
    else $error("Bank active too early after row open");

endmodule // ddrc_bank

// *** hdl/ddrc_decode.sv ***
// Command decoder and power state control of an eight-bank DDR memory
// Assumes command pins come from off-chip and are synchronised here
`timescale 1ns/100ps
`include "ddrc_map.svh"

module ddrc_decode
  import ddrc_pkg::*;
#(
  parameter int BANKS   = `DDRC_BANKS,
  parameter int RCD_CYC = `DDRC_RCD_CYC
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_cs_n,
  input  wire logic                     i_ras_n,
  input  wire logic                     i_cas_n,
  input  wire logic                     i_we_n,
  input  wire logic                     i_power_down_n,
  input  wire logic [`DDRC_BA_W-1:0]    i_bank,
  input  wire logic [`DDRC_ADDR_W-1:0]  i_addr,
  input  wire logic [`DDRC_LANES-1:0]   i_byte_mask,
  output logic      [BANKS-1:0]         o_bank_active,
  output logic                          o_read_start,
  output logic                          o_store_start,
  output logic                          o_auto_close,
  output logic      [`DDRC_BA_W-1:0]    o_col_bank,
  output logic      [`DDRC_ADDR_W-1:0]  o_col_addr,
  output logic                          o_mode_load,
  output logic      [`DDRC_BA_W+`DDRC_ADDR_W-2:0] o_mode_value,
  output logic                          o_refresh,
  output logic                          o_restore_mode,
  output logic                          o_power_down,
  output logic                          o_dq_hiz,
  output logic      [`DDRC_LANES-1:0]   o_lane_block
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  localparam int SW = 5 + `DDRC_BA_W + `DDRC_ADDR_W + `DDRC_LANES;

  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic          cs_n;
  logic          ras_n;
  logic          cas_n;
  logic          we_n;
  logic          pd_n;
  logic          pd_n_prev_q;
  logic [`DDRC_BA_W-1:0]   bank;
  logic [`DDRC_ADDR_W-1:0] addr;
  logic [`DDRC_LANES-1:0]  mask;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= {i_cs_n, i_ras_n, i_cas_n, i_we_n, i_power_down_n,
                  i_bank, i_addr, i_byte_mask};
      sync2_q <= sync1_q;
    end
  end

  assign {cs_n, ras_n, cas_n, we_n, pd_n, bank, addr, mask} = sync2_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_n_prev_q <= 1'b1;
    end else begin
      pd_n_prev_q <= pd_n;
    end
  end

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  ddrc_cmd_t cmd;
  logic      close_bit;

  assign close_bit = addr[`DDRC_CLOSE_BIT];

  always_comb begin
    if (cs_n) begin
      cmd = DDRC_CMD_NOP;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h7:    cmd = DDRC_CMD_NOP;
        3'h6:    cmd = DDRC_CMD_RESERVED;
        3'h5:    cmd = DDRC_CMD_READ;
        3'h4:    cmd = DDRC_CMD_STORE;
        3'h3:    cmd = DDRC_CMD_ROW_OPEN;
        3'h2:    cmd = close_bit ? DDRC_CMD_SHUT_ALL : DDRC_CMD_SHUT_ONE;
        3'h1:    cmd = DDRC_CMD_REFRESH;
        3'h0:    cmd = close_bit ? DDRC_CMD_RESERVED : DDRC_CMD_MODE_LOAD;
        default: cmd = DDRC_CMD_NOP;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Power state
  // --------------------------------------------------------------------------
  ddrc_pwr_t pwr_q;
  logic      awake;
  logic      cmd_ok;

  assign awake  = (pwr_q == DDRC_PWR_IDLE) && pd_n_prev_q && pd_n;
  assign cmd_ok = awake;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_q <= DDRC_PWR_IDLE;
    end else begin
      case (pwr_q)
        DDRC_PWR_IDLE: begin
          if (pd_n_prev_q && !pd_n) begin
            if (cmd == DDRC_CMD_REFRESH) begin
              pwr_q <= DDRC_PWR_RESTORE;
            end else if (cmd == DDRC_CMD_NOP) begin
              pwr_q <= DDRC_PWR_DOWN;
            end
          end
        end
        DDRC_PWR_RESTORE: begin
          if (pd_n && cmd == DDRC_CMD_NOP) begin
            pwr_q <= DDRC_PWR_IDLE;
          end
        end
        DDRC_PWR_DOWN: begin
          if (pd_n && cmd == DDRC_CMD_NOP) begin
            pwr_q <= DDRC_PWR_IDLE;
          end
        end
        default: pwr_q <= DDRC_PWR_IDLE;
      endcase
    end
  end

  assign o_restore_mode = (pwr_q == DDRC_PWR_RESTORE);
  assign o_power_down   = (pwr_q == DDRC_PWR_DOWN);
  assign o_dq_hiz       = (pwr_q != DDRC_PWR_IDLE);

  // --------------------------------------------------------------------------
  // Banks
  // --------------------------------------------------------------------------
  logic [BANKS-1:0] bank_idle;
  logic [BANKS-1:0] col_auto_shut;

  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      logic sel;
      logic open_b;
      logic shut_b;
      assign sel    = (bank == `DDRC_BA_W'(g));
      assign open_b = cmd_ok && cmd == DDRC_CMD_ROW_OPEN && sel;
      assign shut_b = (cmd_ok && ((cmd == DDRC_CMD_SHUT_ONE && sel) ||
                                  cmd == DDRC_CMD_SHUT_ALL)) ||
                      col_auto_shut[g];
      ddrc_bank #(
        .RCD_CYC (RCD_CYC)
      ) u_bank (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_open   (open_b),
        .i_shut   (shut_b),
        .o_active (o_bank_active[g]),
        .o_idle   (bank_idle[g])
      );
      assign col_auto_shut[g] = cmd_ok && close_bit && sel && o_bank_active[g] &&
                                (cmd == DDRC_CMD_READ || cmd == DDRC_CMD_STORE);
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Column, mode and refresh strobes
  // --------------------------------------------------------------------------
  logic col_ok;

  assign col_ok = cmd_ok && o_bank_active[bank];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_read_start  <= 1'b0;
      o_store_start <= 1'b0;
      o_auto_close  <= 1'b0;
      o_col_bank    <= '0;
      o_col_addr    <= '0;
    end else begin
      o_read_start  <= col_ok && cmd == DDRC_CMD_READ;
      o_store_start <= col_ok && cmd == DDRC_CMD_STORE;
      if (col_ok && (cmd == DDRC_CMD_READ || cmd == DDRC_CMD_STORE)) begin
        o_auto_close <= close_bit;
        o_col_bank   <= bank;
        o_col_addr   <= addr;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mode_load  <= 1'b0;
      o_mode_value <= '0;
      o_refresh    <= 1'b0;
    end else begin
      o_mode_load <= cmd_ok && cmd == DDRC_CMD_MODE_LOAD && &bank_idle;
      if (cmd_ok && cmd == DDRC_CMD_MODE_LOAD && &bank_idle) begin
        o_mode_value <= {bank, addr[`DDRC_CLOSE_BIT-1:0]};
      end
      o_refresh <= cmd_ok && cmd == DDRC_CMD_REFRESH && &bank_idle;
    end
  end

  // --------------------------------------------------------------------------
  // Byte lane blocking
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lane_block <= '0;
    end else begin
      o_lane_block <= pd_n_prev_q ? mask : '0;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  AST_SHUT_ALL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_ok && cmd == DDRC_CMD_SHUT_ALL) |=> (o_bank_active == '0))
    else $error("Shut-all left a bank active");

  AST_SHUT_ONE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_ok && cmd == DDRC_CMD_SHUT_ONE && o_bank_active[bank])
      |=> !o_bank_active[$past(bank)])
    else $error("Shut-one did not close named bank");

  AST_NOP_STILL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd == DDRC_CMD_NOP && awake)
      |=> (((~o_bank_active & $past(o_bank_active)) == '0) && pwr_q == DDRC_PWR_IDLE))
    else $error("No-op changed bank or power state");

  AST_RESTORE_IN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (pwr_q == DDRC_PWR_IDLE && pd_n_prev_q && !pd_n && cmd == DDRC_CMD_REFRESH)
      |=> o_restore_mode && o_dq_hiz)
    else $error("Refresh with power-down low did not enter restore");

  AST_RESTORE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_restore_mode && !pd_n) |=> o_restore_mode)
    else $error("Restore left while power-down low");

  AST_PDOWN_EXIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_power_down && pd_n && cmd == DDRC_CMD_NOP) |=> !o_power_down ##1 !o_dq_hiz)
    else $error("Power-down exit failed");

  AST_READ_GO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (col_ok && cmd == DDRC_CMD_READ) |=> o_read_start && !o_store_start
      && o_auto_close == $past(close_bit))
    else $error("Read start or auto-close wrong");

  AST_MODE_VAL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_ok && cmd == DDRC_CMD_MODE_LOAD && &bank_idle)
      |=> o_mode_value[2:0] == $past(addr[2:0]))
    else $error("Mode value not captured");

  AST_LANE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (pd_n_prev_q && mask[3]) |=> o_lane_block[3])
    else $error("Lane 3 not blocked");

  AST_REFRESH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_refresh |-> $past(&bank_idle) && $past(pd_n) && $past(pd_n_prev_q))
    else $error("Refresh strobe without closed banks");

endmodule // ddrc_decode

// *** hdl/ddrc_map.svh ***
// Offsets-free constants for the command decoder: widths and timing counts
// Assumes inclusion by bare name from design files
`ifndef DDRC_MAP_SVH
`define DDRC_MAP_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define DDRC_BANKS        8
`define DDRC_BA_W         3
`define DDRC_ADDR_W       11
`define DDRC_LANES        4
`define DDRC_CLOSE_BIT    10

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DDRC_CLK_PERIOD_NS 20
`define DDRC_RCD_NS        30
`define DDRC_RCD_CYC       ((`DDRC_RCD_NS + `DDRC_CLK_PERIOD_NS - 1) / `DDRC_CLK_PERIOD_NS)

`endif

// *** hdl/ddrc_pkg.sv ***
// Types shared by the command decoder files
// Assumes nothing beyond a SystemVerilog compiler
package ddrc_pkg;

  typedef enum logic [3:0] {
    DDRC_CMD_NOP,
    DDRC_CMD_RESERVED,
    DDRC_CMD_READ,
    DDRC_CMD_STORE,
    DDRC_CMD_ROW_OPEN,
    DDRC_CMD_SHUT_ONE,
    DDRC_CMD_SHUT_ALL,
    DDRC_CMD_REFRESH,
    DDRC_CMD_MODE_LOAD
  } ddrc_cmd_t;

  typedef enum logic [1:0] {
    DDRC_PWR_IDLE,
    DDRC_PWR_RESTORE,
    DDRC_PWR_DOWN
  } ddrc_pwr_t;

  typedef enum logic [1:0] {
    DDRC_BANK_IDLE,
    DDRC_BANK_OPENING,
    DDRC_BANK_ACTIVE
  } ddrc_bank_t;

endpackage
